// file: hw/mode_priv_stack.sv
// processor mode, execution privilege and stack pointer selection
// assumes core decode delivers one-cycle strobes synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "mode_priv_regs.svh"
module mode_priv_stack
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // exception flow
   input wire mode_priv_pkg::exc_ev_t excEv,
   // decoded instructions
   input wire mode_priv_pkg::instr_t instr,
   // data access and optional region restriction
   input wire mode_priv_pkg::mem_req_t memReq,
   input wire logic regionRestricted,
   // stack operations
   input wire mode_priv_pkg::stack_op_t stackOp,
   // status
   output mode_priv_pkg::mode_t mode,
   output logic privileged,
   output logic [1:0] ctrl,
   output logic useProcessStack,
   output logic [31:0] mainSp,
   output logic [31:0] processSp,
   output logic [31:0] activeSp,
   // push write port
   output logic pushWrite,
   output logic [31:0] pushAddr,
   // faults and supervisor call
   output logic instrFault,
   output logic accessFault,
   output logic svcRequest
);
   logic [1:0] next_ctrl;
   logic [31:0] next_sp;

   function automatic logic in_sys_space(input logic [31:0] a);
      in_sys_space = (a & `SYS_SPACE_MASK) == `SYS_SPACE_BASE;
   endfunction : in_sys_space

   // mode tracking
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         mode <= mode_priv_pkg::THREAD;
      else if (excEv.exceptionEntry)
         mode <= mode_priv_pkg::HANDLER;
      else if (excEv.exceptionReturn)
         mode <= mode_priv_pkg::THREAD;
   end

   assign privileged = (mode == mode_priv_pkg::HANDLER) || !ctrl[`CTRL_NPRIV_BIT];
   assign useProcessStack = (mode == mode_priv_pkg::THREAD) && ctrl[`CTRL_SPSEL_BIT];

   always_comb
   begin
      next_ctrl = ctrl;
      if (instr.ctrlWrite && privileged)
         next_ctrl = instr.ctrlData;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         ctrl <= `CTRL_RESET;
      else
         ctrl <= next_ctrl;
   end

   // stacks
   assign activeSp = useProcessStack ? processSp : mainSp;
   assign next_sp = activeSp - `WORD_BYTES;

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         mainSp <= `SP_RESET;
      else if (stackOp.spWrite && stackOp.spWriteMain)
         mainSp <= stackOp.spData;
      else if (stackOp.push && !useProcessStack)
         mainSp <= next_sp;
      else if (stackOp.pop && !useProcessStack)
         mainSp <= mainSp + `WORD_BYTES;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
         processSp <= `SP_RESET;
      else if (stackOp.spWrite && !stackOp.spWriteMain)
         processSp <= stackOp.spData;
      else if (stackOp.push && useProcessStack)
         processSp <= next_sp;
      else if (stackOp.pop && useProcessStack)
         processSp <= processSp + `WORD_BYTES;
   end

   // push write strobe and address register on the same edge as the decrement
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         pushWrite <= 1'b0;
         pushAddr <= `SP_RESET;
      end
      else
      begin
         pushWrite <= stackOp.push;
         pushAddr <= next_sp;
      end
   end

   // privilege checks
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         instrFault <= 1'b0;
         accessFault <= 1'b0;
         svcRequest <= 1'b0;
      end
      else
      begin
         instrFault <= !privileged && (instr.changeStateInstr ||
            ((instr.specialRegWriteInstr || instr.specialRegReadInstr) && instr.specialRegSel > `SPECREG_OPEN_MAX));
         accessFault <= !privileged && memReq.valid && (in_sys_space(memReq.addr) || regionRestricted);
         svcRequest <= instr.supervisorCallInstr;
      end
   end

   property p_handler_priv;
      @(posedge clk_sys) disable iff (!nrst) mode == mode_priv_pkg::HANDLER |-> privileged;
   endproperty
   a_handler_priv: assert property (p_handler_priv) else $error("handler not privileged");
   property p_mode_hold;
      @(posedge clk_sys) disable iff (!nrst)
      !excEv.exceptionEntry && !excEv.exceptionReturn |=> $stable(mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed without exception event");
   property p_reset_sps;
      @(posedge clk_sys) !nrst |=> mainSp == `SP_RESET && processSp == `SP_RESET && !pushWrite;
   endproperty
   a_reset_sps: assert property (p_reset_sps) else $error("reset pointers wrong");

   property p_reset_thread;
      @(posedge clk_sys) !nrst |=> mode == mode_priv_pkg::THREAD && ctrl == `CTRL_RESET;
   endproperty
   a_reset_thread: assert property (p_reset_thread) else $error("reset state wrong");
   property p_entry;
      @(posedge clk_sys) disable iff (!nrst) excEv.exceptionEntry |=> mode == mode_priv_pkg::HANDLER;
   endproperty
   a_entry: assert property (p_entry) else $error("no handler entry");
   property p_return;
      @(posedge clk_sys) disable iff (!nrst)
      excEv.exceptionReturn && !excEv.exceptionEntry |=> mode == mode_priv_pkg::THREAD;
   endproperty
   a_return: assert property (p_return) else $error("no thread return");
   property p_thread_priv;
      @(posedge clk_sys) disable iff (!nrst)
      mode == mode_priv_pkg::THREAD |-> privileged == !ctrl[`CTRL_NPRIV_BIT];
   endproperty
   a_thread_priv: assert property (p_thread_priv) else $error("thread privilege wrong");
   property p_ctrl_guard;
      @(posedge clk_sys) disable iff (!nrst) !privileged |=> $stable(ctrl);
   endproperty
   a_ctrl_guard: assert property (p_ctrl_guard) else $error("unprivileged control change");
   property p_cps;
      @(posedge clk_sys) disable iff (!nrst) !privileged && instr.changeStateInstr |=> instrFault;
   endproperty
   a_cps: assert property (p_cps) else $error("change-state not barred");
   property p_sys;
      @(posedge clk_sys) disable iff (!nrst)
      !privileged && memReq.valid && in_sys_space(memReq.addr) |=> accessFault;
   endproperty
   a_sys: assert property (p_sys) else $error("system space not barred");
   property p_priv_free;
      @(posedge clk_sys) disable iff (!nrst) privileged |=> !instrFault && !accessFault;
   endproperty
   a_priv_free: assert property (p_priv_free) else $error("privileged code faulted");
   property p_svc;
      @(posedge clk_sys) disable iff (!nrst) instr.supervisorCallInstr |=> svcRequest;
   endproperty
   a_svc: assert property (p_svc) else $error("supervisor call lost");
   property p_push;
      @(posedge clk_sys) disable iff (!nrst) stackOp.push && !stackOp.spWrite |=> pushWrite &&
      pushAddr == $past(activeSp) - `WORD_BYTES && ($past(useProcessStack) ? processSp : mainSp) == pushAddr;
   endproperty
   a_push: assert property (p_push) else $error("push order wrong");
   property p_pop;
      @(posedge clk_sys) disable iff (!nrst) stackOp.pop && !stackOp.push && !stackOp.spWrite |=>
      ($past(useProcessStack) ? processSp : mainSp) == $past(activeSp) + `WORD_BYTES;
   endproperty
   a_pop: assert property (p_pop) else $error("pop step wrong");
   property p_handler_msp;
      @(posedge clk_sys) disable iff (!nrst) mode == mode_priv_pkg::HANDLER |-> activeSp == mainSp;
   endproperty
   a_handler_msp: assert property (p_handler_msp) else $error("handler not on main stack");
   property p_thread_sel;
      @(posedge clk_sys) disable iff (!nrst)
      mode == mode_priv_pkg::THREAD |-> useProcessStack == ctrl[`CTRL_SPSEL_BIT];
   endproperty
   a_thread_sel: assert property (p_thread_sel) else $error("thread stack select wrong");
   property p_psp_hold;
      @(posedge clk_sys) disable iff (!nrst) !useProcessStack && !stackOp.spWrite |=> $stable(processSp);
   endproperty
   a_psp_hold: assert property (p_psp_hold) else $error("process stack disturbed");
   property p_msp_hold;
      @(posedge clk_sys) disable iff (!nrst) useProcessStack && !stackOp.spWrite |=> $stable(mainSp);
   endproperty
   a_msp_hold: assert property (p_msp_hold) else $error("main stack disturbed");
   property p_region;
      @(posedge clk_sys) disable iff (!nrst)
      !privileged && memReq.valid && regionRestricted |=> accessFault;
   endproperty
   a_region: assert property (p_region) else $error("restricted region not barred");

   c_exc_entry: cover property (@(posedge clk_sys) disable iff (!nrst) excEv.exceptionEntry);

   c_handler_round: cover property (@(posedge clk_sys) disable iff (!nrst)
      excEv.exceptionEntry ##[1:20] excEv.exceptionReturn);
   c_unpriv_svc: cover property (@(posedge clk_sys) disable iff (!nrst)
      !privileged && instr.supervisorCallInstr);
   c_psp_push: cover property (@(posedge clk_sys) disable iff (!nrst) useProcessStack && stackOp.push);
   c_pop: cover property (@(posedge clk_sys) disable iff (!nrst)
      stackOp.pop && !stackOp.push && !stackOp.spWrite);
endmodule : mode_priv_stack
`default_nettype wire

// file: hw/mode_priv_regs.svh
// constants for the mode, privilege and stack block
// assumes a 32-bit core datapath around it
// Notes on behaviour
// - leaving reset, execution starts in Thread mode
// - exceptions run in Handler mode; return goes back to Thread
// - Handler mode is always privileged, whatever the control setting
// - in Thread mode a control bit picks privileged or unprivileged
// - only privileged code may change the Thread privilege bit
// - unprivileged code cannot use change-state; special moves restricted
// - unprivileged code cannot reach timer, interrupt controller, control block
// - unprivileged access to chosen regions may be restricted too
// - privileged code may run everything and reach everything
// - supervisor call from unprivileged code hands control to privileged code
// - stacks are full descending; pointer holds last stacked item
// - a push decrements the pointer first, then writes the item
// - in Thread mode a control bit picks main or process stack
// - Handler mode always uses the main stack
`ifndef MODE_PRIV_REGS_SVH
`define MODE_PRIV_REGS_SVH
`define CTRL_NPRIV_BIT 0
`define CTRL_SPSEL_BIT 1
`define CTRL_RESET 2'h0
`define SP_RESET 32'h0000_0000
`define WORD_BYTES 32'h0000_0004
`define SYS_SPACE_BASE 32'he000_e000
`define SYS_SPACE_MASK 32'hffff_f000
`define SPECREG_OPEN_MAX 8'h03
`endif

// file: hw/mode_priv_pkg.sv
// types for the mode, privilege and stack block
// assumes the constants header is included by users of the package
`default_nettype none
package mode_priv_pkg;
   typedef enum logic [1:0] {THREAD = 2'b00, HANDLER = 2'b01} mode_t;
   typedef struct packed {
      logic exceptionEntry;
      logic exceptionReturn;
   } exc_ev_t;
   typedef struct packed {
      logic ctrlWrite;
      logic [1:0] ctrlData;
      logic changeStateInstr;
      logic specialRegWriteInstr;
      logic specialRegReadInstr;
      logic [7:0] specialRegSel;
      logic supervisorCallInstr;
   } instr_t;
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
   } mem_req_t;
   typedef struct packed {
      logic push;
      logic pop;
      logic spWrite;
      logic spWriteMain;
      logic [31:0] spData;
   } stack_op_t;
endpackage : mode_priv_pkg
`default_nettype wire

// file: bench/processor_mode_privilege_stack_bench.sv
// self-checking bench for the mode, privilege and stack block
// assumes the package, header and design module under hw/ are compiled first
`timescale 1ns/1ps
`default_nettype none
module processor_mode_privilege_stack_bench;
   typedef struct {
      logic [1:0] ev, em, ec;
      logic [2:0] cw;
      logic [3:0] op, so, ef;
      logic [7:0] sel;
      logic [31:0] ma, sd, esp;
      logic rr, ep;
   } row_t;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   mode_priv_pkg::exc_ev_t excEv = '0;
   mode_priv_pkg::instr_t instr = '0;
   mode_priv_pkg::mem_req_t memReq = '0;
   logic regionRestricted = 1'b0;
   mode_priv_pkg::stack_op_t stackOp = '0;
   mode_priv_pkg::mode_t mode;
   logic privileged, useProcessStack, pushWrite, instrFault, accessFault, svcRequest;
   logic [1:0] ctrl;
   logic [31:0] mainSp, processSp, activeSp, pushAddr;
   int failCount = 0;
   int samplesChecked = 0;
   row_t rows[$];
   mode_priv_stack mode_priv_stack_inst (.clk_sys(clk_sys), .nrst(nrst), .excEv(excEv), .instr(instr),
      .memReq(memReq), .regionRestricted(regionRestricted), .stackOp(stackOp), .mode(mode),
      .privileged(privileged), .ctrl(ctrl), .useProcessStack(useProcessStack), .mainSp(mainSp),
      .processSp(processSp), .activeSp(activeSp), .pushWrite(pushWrite), .pushAddr(pushAddr),
      .instrFault(instrFault), .accessFault(accessFault), .svcRequest(svcRequest));
   initial
   begin
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samplesChecked++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         failCount++;
      end
   endtask : chk
   function automatic void add(input logic [1:0] ev, em, ec, input logic [2:0] cw, input logic [3:0] op, so, ef,
      input logic [7:0] sel, input logic [31:0] ma, sd, esp, input logic rr, ep);
      rows.push_back(row_t'{ev, em, ec, cw, op, so, ef, sel, ma, sd, esp, rr, ep});
   endfunction : add
   // one row held for one cycle, results seen after the sampling edge
   task automatic run(input row_t r);
      @(posedge clk_sys);
      excEv <= r.ev;
      instr <= {r.cw, r.op[3:1], r.sel, r.op[0]};
      memReq <= {r.ma != 32'h0, r.ma};
      regionRestricted <= r.rr;
      stackOp <= {r.so, r.sd};
      @(posedge clk_sys);
      excEv <= '0;
      instr <= '0;
      memReq <= '0;
      regionRestricted <= 1'b0;
      stackOp <= '0;
      #1;
      chk("mode", 32'(r.em), 32'(mode));
      chk("privileged", 32'(r.ep), 32'(privileged));
      chk("ctrl", 32'(r.ec), 32'(ctrl));
      chk("useProcessStack", 32'(r.em == 2'h0 && r.ec[1]), 32'(useProcessStack));
      chk("activeSp", r.esp, activeSp);
      chk("pulses", 32'(r.ef), 32'({pushWrite, instrFault, accessFault, svcRequest}));
      if (r.ef[3])
         chk("pushAddr", r.esp, pushAddr);
      @(posedge clk_sys);
      #1;
      chk("pulses low", 32'h0, 32'({pushWrite, instrFault, accessFault, svcRequest}));
   endtask : run
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      add(2'h0, 2'h0, 2'h0, 3'h0, 4'h0, 4'h8, 4'h8, 8'h00, 32'h0, 32'h0, 32'hffff_fffc, 1'b0, 1'b1);
      add(2'h0, 2'h0, 2'h0, 3'h0, 4'h0, 4'h2, 4'h0, 8'h00, 32'h0, 32'h100, 32'hffff_fffc, 1'b0, 1'b1);
      add(2'h0, 2'h0, 2'h0, 3'h0, 4'hc, 4'h0, 4'h0, 8'hff, 32'he000_e010, 32'h0, 32'hffff_fffc, 1'b0, 1'b1);
      add(2'h0, 2'h0, 2'h2, 3'h6, 4'h0, 4'h0, 4'h0, 8'h00, 32'h0, 32'h0, 32'h100, 1'b0, 1'b1);
      add(2'h0, 2'h0, 2'h2, 3'h0, 4'h0, 4'h8, 4'h8, 8'h00, 32'h0, 32'h0, 32'hfc, 1'b0, 1'b1);
      add(2'h2, 2'h1, 2'h2, 3'h0, 4'h0, 4'h0, 4'h0, 8'h00, 32'h0, 32'h0, 32'hffff_fffc, 1'b0, 1'b1);
      add(2'h0, 2'h1, 2'h3, 3'h7, 4'h0, 4'h0, 4'h0, 8'h00, 32'h0, 32'h0, 32'hffff_fffc, 1'b0, 1'b1);
      add(2'h0, 2'h1, 2'h3, 3'h0, 4'h8, 4'h8, 4'h8, 8'h00, 32'he000_e100, 32'h0, 32'hffff_fff8, 1'b0, 1'b1);
      add(2'h1, 2'h0, 2'h3, 3'h0, 4'h0, 4'h0, 4'h0, 8'h00, 32'h0, 32'h0, 32'hfc, 1'b0, 1'b0);
      add(2'h0, 2'h0, 2'h3, 3'h0, 4'h8, 4'h0, 4'h4, 8'h00, 32'h0, 32'h0, 32'hfc, 1'b0, 1'b0);
      add(2'h0, 2'h0, 2'h3, 3'h0, 4'h4, 4'h0, 4'h0, 8'h03, 32'h0, 32'h0, 32'hfc, 1'b0, 1'b0);
      add(2'h0, 2'h0, 2'h3, 3'h0, 4'h2, 4'h0, 4'h4, 8'h04, 32'h0, 32'h0, 32'hfc, 1'b0, 1'b0);
      add(2'h0, 2'h0, 2'h3, 3'h0, 4'h0, 4'h0, 4'h2, 8'h00, 32'he000_effc, 32'h0, 32'hfc, 1'b0, 1'b0);
      add(2'h0, 2'h0, 2'h3, 3'h0, 4'h0, 4'h0, 4'h0, 8'h00, 32'he000_f000, 32'h0, 32'hfc, 1'b0, 1'b0);
      add(2'h0, 2'h0, 2'h3, 3'h0, 4'h0, 4'h0, 4'h2, 8'h00, 32'h2000_0000, 32'h0, 32'hfc, 1'b1, 1'b0);
      add(2'h0, 2'h0, 2'h3, 3'h4, 4'h0, 4'h0, 4'h0, 8'h00, 32'h0, 32'h0, 32'hfc, 1'b0, 1'b0);
      add(2'h0, 2'h0, 2'h3, 3'h0, 4'h1, 4'h0, 4'h1, 8'h00, 32'h0, 32'h0, 32'hfc, 1'b0, 1'b0);
      add(2'h3, 2'h1, 2'h3, 3'h0, 4'h0, 4'h0, 4'h0, 8'h00, 32'h0, 32'h0, 32'hffff_fff8, 1'b0, 1'b1);
      add(2'h0, 2'h1, 2'h3, 3'h0, 4'h0, 4'h4, 4'h0, 8'h00, 32'h0, 32'h0, 32'hffff_fffc, 1'b0, 1'b1);
      add(2'h0, 2'h1, 2'h3, 3'h0, 4'h0, 4'hc, 4'h8, 8'h00, 32'h0, 32'h0, 32'hffff_fff8, 1'b0, 1'b1);
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      foreach (rows[k])
         run(rows[k]);
      $display("table test done");
      // reset again from Handler mode with both pointers moved
      @(posedge clk_sys);
      nrst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("reset mode", 32'h0, 32'(mode));
      chk("reset ctrl", 32'h0, 32'({privileged, ctrl}) ^ 32'h4);
      chk("reset sps", 32'h0, mainSp | processSp);
      @(posedge clk_sys);
      nrst <= 1'b1;
      $display("reset test done");
      // two pushes back to back on the main stack
      @(posedge clk_sys);
      stackOp <= {4'h8, 32'h0};
      @(posedge clk_sys);
      @(posedge clk_sys);
      stackOp <= '0;
      #1;
      chk("second push", 32'hffff_fff8, mainSp);
      chk("second push addr", 32'hffff_fff8, pushAddr);
      chk("second push strobe", 32'h1, 32'(pushWrite));
      $display("back to back push test done");
      give_verdict();
   end
endmodule : processor_mode_privilege_stack_bench
`default_nettype wire
